// ==== core/nsf_pkg.sv ====
package nsf_pkg;

    // Register byte offsets
    localparam logic [7:0] NSF_CTRL_OFS   = 8'h00;
    localparam logic [7:0] NSF_STATUS_OFS = 8'h04;
    localparam logic [7:0] NSF_CMD_OFS    = 8'h08;

    // Control register fields
    localparam int NSF_CTRL_FEED_EN_BIT  = 0;
    localparam int NSF_CTRL_FEED_SET_BIT = 1;
    localparam int NSF_CTRL_LIFE_EN_BIT  = 2;
    localparam int NSF_CTRL_MODE_LSB     = 3;
    localparam int NSF_CTRL_W            = 5;
    localparam logic [NSF_CTRL_W-1:0] NSF_CTRL_RESET = 5'h0_0;

    // Command register field
    localparam int NSF_CMD_PANEL_RST_BIT = 0;

    // Status register layout width (flag bits in low end)
    localparam int NSF_STATUS_W = 12;

    // Asynchronous pin inputs, one synchroniser each
    localparam int NSF_ASYNC_W        = 4;
    localparam int NSF_ASYNC_CELL_LOW = 0;
    localparam int NSF_ASYNC_ABS_FLT  = 1;
    localparam int NSF_ASYNC_SPD_FLT  = 2;
    localparam int NSF_ASYNC_INCH     = 3;

    // Power-on sequencing: check once the synchronisers are full
    localparam logic [1:0] NSF_BOOT_CHECK = 2'h2;
    localparam logic [1:0] NSF_BOOT_DONE  = 2'h3;

    // Single-digit feed code range
    localparam logic [2:0] NSF_FEED_CODE_MIN = 3'h1;
    localparam logic [2:0] NSF_FEED_CODE_MAX = 3'h5;

    localparam int NSF_SPINDLES = 2;
    localparam int NSF_SPEED_W  = 16;

    typedef enum logic [1:0] {
        NSF_LIFE_PER_TOOL = 2'b00,
        NSF_LIFE_LATHE    = 2'b01,
        NSF_LIFE_MC       = 2'b10,
        NSF_LIFE_NONE     = 2'b11
    } nsf_life_mode_e;

    // Controller motion events, same clock, one-cycle pulses
    typedef struct packed {
        logic       feed_cmd;
        logic [2:0] feed_code;
        logic       block_done;
        logic       auto_operation_pause;
        logic       interlock_stop;
        logic       nc_reset;
    } nsf_motion_s;

    // Tool life events; pulses except the two level qualifiers
    typedef struct packed {
        logic count_reached;
        logic last_tool;
        logic tool_change_reset;
        logic tool_function_strobe;
        logic group_select_done;
        logic group_all_expired;
        logic usage_cleared;
        logic spindle_tool_change;
        logic tool_error;
    } nsf_tool_s;

    // Flags presented to the ladder program, all levels
    typedef struct packed {
        logic                    speed_alarm;
        logic                    abs_alarm;
        logic                    backup_cell_low_alarm;
        logic                    tool_group_expired;
        logic [NSF_SPINDLES-1:0] spindle_below_min_speed;
        logic [NSF_SPINDLES-1:0] spindle_above_max_speed;
        logic                    tool_wear_tracking_active;
        logic                    single_digit_feed_active;
        logic                    position_display_frozen_flag;
        logic                    inch_unit_flag;
    } nsf_flags_s;

endpackage : nsf_pkg

// ==== core/nsf_status_flags.sv ====
`timescale 1ns/1ns
// Contract
// - Imperial flag reflects inch setup strap captured only at power-on.
// - Unit selection program commands never change the imperial flag.
// - Display-frozen flag follows the freeze request input exactly.
// - Display updates stop immediately when freeze request rises.
// - Single-digit feed flag sets on selection of feed code one to five.
// - Feed flag clears on block done, pause, interlock stop or reset.
// - Feed codes accepted only with enable and feed values set.
// - Tool-wear-tracking flag follows the life management enable.
// - Per spindle, flag measured speed above its maximum.
// - Per spindle, flag measured speed below its minimum.
// - Per-tool mode sets expired flag on count reach; operation continues.
// - Lathe group mode sets expired on last-tool reach, reset, expired strobe.
// - Lathe group mode clears on live group selection or usage clear.
// - Machining mode sets on last-tool reach, tool error, expired mount.
// - Machining mode clears on live mount, usage clear or disable.
// - Machining expired flag never changes in the tool change cycle.
// - Low backup cell checked at power-on raises alarm flag.
// - Detector or speed detector supply fault raises alarm flag.
// - Auto start blocked only by the speed detector supply alarm.
// - Panel reset clears low cell alarm; next power-on rechecks.
// - Supply fault alarms clear only by power cycle.
module nsf_status_flags
    import nsf_pkg::*;
#(
    parameter int SPINDLES = NSF_SPINDLES,
    parameter int SPEED_W  = NSF_SPEED_W
) (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [31:0]                  reg_rdata,
    input  wire logic [NSF_ASYNC_W-1:0]       async_pins,
    input  wire logic                         position_display_freeze_request,
    input  wire nsf_motion_s                  motion,
    input  wire nsf_tool_s                    tool,
    input  wire logic [SPINDLES-1:0][SPEED_W-1:0] spindle_speed_fb,
    input  wire logic [SPINDLES-1:0][SPEED_W-1:0] spindle_max_speed,
    input  wire logic [SPINDLES-1:0][SPEED_W-1:0] spindle_min_speed,
    output nsf_flags_s                        flags,
    output logic                              auto_start_permit
);

    typedef struct packed {
        logic [NSF_ASYNC_W-1:0] sync1;
        logic [NSF_ASYNC_W-1:0] sync2;
        logic [1:0]             boot_cnt;
        logic [NSF_CTRL_W-1:0]  ctrl;
        logic                   mount_pend;
        logic                   mount_expired;
        nsf_flags_s             fl;
        logic [31:0]            rdata;
    } nsf_state_s;

    nsf_state_s     st_reg;
    nsf_state_s     st_next;
    nsf_life_mode_e life_mode;
    logic           life_en;
    logic           feed_ok;
    logic           feed_take;
    logic           ctrl_wr;
    logic           cmd_wr;
    logic [SPINDLES-1:0] above_cmp;
    logic [SPINDLES-1:0] below_cmp;

    // Speed comparators, one pair per spindle
    for (genvar i = 0; i < SPINDLES; i++) begin : g_spindle
        assign above_cmp[i] = spindle_speed_fb[i] > spindle_max_speed[i];
        assign below_cmp[i] = spindle_speed_fb[i] < spindle_min_speed[i];
    end

    // Decoded control fields
    assign life_mode = nsf_life_mode_e'(
        st_reg.ctrl[NSF_CTRL_MODE_LSB +: 2]);
    assign life_en   = st_reg.ctrl[NSF_CTRL_LIFE_EN_BIT];
    assign feed_ok   = st_reg.ctrl[NSF_CTRL_FEED_EN_BIT]
                     & st_reg.ctrl[NSF_CTRL_FEED_SET_BIT];
    assign feed_take = motion.feed_cmd & feed_ok
                     & (motion.feed_code >= NSF_FEED_CODE_MIN)
                     & (motion.feed_code <= NSF_FEED_CODE_MAX);
    assign ctrl_wr   = reg_wr & (reg_addr == NSF_CTRL_OFS);
    assign cmd_wr    = reg_wr & (reg_addr == NSF_CMD_OFS);

    // Next-state logic for every flag and the register slave
    always_comb begin
        st_next = st_reg;

        // Second flop is the only reader of the first
        st_next.sync1 = async_pins;
        st_next.sync2 = st_reg.sync1;

        if (st_reg.boot_cnt != NSF_BOOT_DONE) begin
            st_next.boot_cnt = st_reg.boot_cnt + 2'h1;
        end

        if (ctrl_wr) begin
            st_next.ctrl = reg_wdata[NSF_CTRL_W-1:0];
        end

        // Strap taken once; unit program commands have no path here
        if (st_reg.boot_cnt == NSF_BOOT_CHECK) begin
            st_next.fl.inch_unit_flag =
                st_reg.sync2[NSF_ASYNC_INCH];
        end

        // Freeze is a plain follower: no block boundary wait
        st_next.fl.position_display_frozen_flag =
            position_display_freeze_request;

        // Feed flag: set wins over a clear in the same cycle
        if (motion.block_done | motion.auto_operation_pause
            | motion.interlock_stop | motion.nc_reset) begin
            st_next.fl.single_digit_feed_active = 1'b0;
        end
        if (feed_take) begin
            st_next.fl.single_digit_feed_active = 1'b1;
        end

        st_next.fl.tool_wear_tracking_active = life_en;
        st_next.fl.spindle_above_max_speed   = above_cmp;
        st_next.fl.spindle_below_min_speed   = below_cmp;

        // Mount is judged one cycle after the change itself
        st_next.mount_pend    = 1'b0;
        st_next.mount_expired = tool.group_all_expired;
        if (life_mode == NSF_LIFE_MC) begin
            st_next.mount_pend = tool.spindle_tool_change;
        end

        // Tool life over; only a flag, nothing here halts operation
        unique case (life_mode)
            NSF_LIFE_PER_TOOL: begin
                if (tool.usage_cleared) begin
                    st_next.fl.tool_group_expired = 1'b0;
                end
                if (tool.count_reached) begin
                    st_next.fl.tool_group_expired = 1'b1;
                end
            end
            NSF_LIFE_LATHE: begin
                if ((tool.group_select_done & ~tool.group_all_expired)
                    | tool.usage_cleared) begin
                    st_next.fl.tool_group_expired = 1'b0;
                end
                if ((tool.last_tool & (tool.count_reached
                                       | tool.tool_change_reset))
                    | (tool.tool_function_strobe
                       & tool.group_all_expired)) begin
                    st_next.fl.tool_group_expired = 1'b1;
                end
            end
            NSF_LIFE_MC: begin
                if (!tool.spindle_tool_change) begin
                    if ((st_reg.mount_pend & ~st_reg.mount_expired)
                        | tool.usage_cleared | ~life_en) begin
                        st_next.fl.tool_group_expired = 1'b0;
                    end
                    if ((tool.last_tool & (tool.count_reached
                                           | tool.tool_error))
                        | (st_reg.mount_pend
                           & st_reg.mount_expired)) begin
                        st_next.fl.tool_group_expired = 1'b1;
                    end
                end
            end
            NSF_LIFE_NONE: begin
                st_next.fl.tool_group_expired = 1'b0;
            end
        endcase

        // Low cell: panel reset clears it, power-on check sets it
        if (cmd_wr & reg_wdata[NSF_CMD_PANEL_RST_BIT]) begin
            st_next.fl.backup_cell_low_alarm = 1'b0;
        end
        if (st_reg.boot_cnt == NSF_BOOT_CHECK
            && st_reg.sync2[NSF_ASYNC_CELL_LOW]) begin
            st_next.fl.backup_cell_low_alarm = 1'b1;
        end

        // Supply faults are sticky until the next power-on reset
        if (st_reg.sync2[NSF_ASYNC_ABS_FLT]) begin
            st_next.fl.abs_alarm = 1'b1;
        end
        if (st_reg.sync2[NSF_ASYNC_SPD_FLT]) begin
            st_next.fl.speed_alarm = 1'b1;
        end

        // Read data valid in the cycle after the strobe only
        st_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                NSF_CTRL_OFS: begin
                    st_next.rdata[NSF_CTRL_W-1:0] = st_reg.ctrl;
                end
                NSF_STATUS_OFS: begin
                    st_next.rdata[NSF_STATUS_W-1:0] = st_reg.fl;
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // State register; synchronous reset models a power cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags             = st_reg.fl;
    assign reg_rdata         = st_reg.rdata;
    // Cell and position supply alarms still let the cycle start
    assign auto_start_permit = ~st_reg.fl.speed_alarm;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence mc_mount_expired_s;
        life_mode == NSF_LIFE_MC && tool.spindle_tool_change
            && tool.group_all_expired;
    endsequence

    sequence mc_quiet_s;
        !tool.spindle_tool_change;
    endsequence

    // Mount of a group that still has live tools
    sequence mc_mount_live_s;
        life_mode == NSF_LIFE_MC && tool.spindle_tool_change
            && !tool.group_all_expired;
    endsequence

    // Cycle after the mount with no competing set event
    sequence mc_idle_s;
        life_mode == NSF_LIFE_MC && !tool.spindle_tool_change
            && !tool.last_tool;
    endsequence

    inch_hold_a: assert property (
        st_reg.boot_cnt == NSF_BOOT_DONE |=> $stable(flags.inch_unit_flag))
        else $error("imperial flag changed after power-on");

    freeze_follow_a: assert property (
        ##1 flags.position_display_frozen_flag
            == $past(position_display_freeze_request))
        else $error("frozen flag does not follow request");

    feed_accept_a: assert property (
        motion.feed_cmd && !feed_ok
            && !flags.single_digit_feed_active
        |=> !flags.single_digit_feed_active)
        else $error("feed code accepted while disabled");

    feed_clear_a: assert property (
        (motion.block_done || motion.nc_reset) && !feed_take
        |=> !flags.single_digit_feed_active)
        else $error("feed flag not cleared");

    wear_follow_a: assert property (
        life_en [*2] |-> flags.tool_wear_tracking_active)
        else $error("wear tracking flag missing");

    spindle_max_a: assert property (
        above_cmp[0] |=> flags.spindle_above_max_speed[0])
        else $error("above-max flag missing");

    spindle_min_a: assert property (
        below_cmp[0] |=> flags.spindle_below_min_speed[0])
        else $error("below-min flag missing");

    mc_change_hold_a: assert property (
        life_mode == NSF_LIFE_MC && tool.spindle_tool_change
        |=> $stable(flags.tool_group_expired))
        else $error("expired flag moved in change cycle");

    mc_mount_set_a: assert property (
        mc_mount_expired_s ##1 mc_quiet_s
        |=> flags.tool_group_expired)
        else $error("expired mount not flagged");

    start_block_a: assert property (
        st_reg.sync2[NSF_ASYNC_SPD_FLT] |=> !auto_start_permit)
        else $error("auto start allowed with speed alarm");

    supply_sticky_a: assert property (
        flags.abs_alarm |=> flags.abs_alarm)
        else $error("supply alarm cleared without power cycle");

    feed_set_a: assert property (
        feed_take |=> flags.single_digit_feed_active)
        else $error("feed flag not set");

    feed_range_a: assert property (
        motion.feed_cmd && !flags.single_digit_feed_active
            && (motion.feed_code < NSF_FEED_CODE_MIN
                || motion.feed_code > NSF_FEED_CODE_MAX)
        |=> !flags.single_digit_feed_active)
        else $error("feed code outside range accepted");

    feed_stop_a: assert property (
        (motion.auto_operation_pause || motion.interlock_stop)
            && !feed_take
        |=> !flags.single_digit_feed_active)
        else $error("feed flag kept after stop");

    feed_hold_a: assert property (
        flags.single_digit_feed_active && !motion.block_done
            && !motion.auto_operation_pause
            && !motion.interlock_stop && !motion.nc_reset
        |=> flags.single_digit_feed_active)
        else $error("feed flag dropped without cause");

    inch_boot_a: assert property (
        st_reg.boot_cnt == NSF_BOOT_CHECK
        |=> flags.inch_unit_flag == $past(st_reg.sync2[NSF_ASYNC_INCH]))
        else $error("imperial strap not captured");

    cell_boot_a: assert property (
        st_reg.boot_cnt == NSF_BOOT_CHECK
            && st_reg.sync2[NSF_ASYNC_CELL_LOW]
        |=> flags.backup_cell_low_alarm)
        else $error("weak cell not flagged at power-on");

    cell_clear_a: assert property (
        cmd_wr && reg_wdata[NSF_CMD_PANEL_RST_BIT]
            && st_reg.boot_cnt == NSF_BOOT_DONE
        |=> !flags.backup_cell_low_alarm)
        else $error("panel reset left cell alarm");

    abs_set_a: assert property (
        st_reg.sync2[NSF_ASYNC_ABS_FLT] |=> flags.abs_alarm)
        else $error("position supply fault not flagged");

    speed_set_a: assert property (
        st_reg.sync2[NSF_ASYNC_SPD_FLT] |=> flags.speed_alarm)
        else $error("speed supply fault not flagged");

    wear_clear_a: assert property (
        (!life_en) [*2] |-> !flags.tool_wear_tracking_active)
        else $error("wear tracking flag without enable");

    above_vec_a: assert property (
        ##1 flags.spindle_above_max_speed == $past(above_cmp))
        else $error("above-max flags off");

    below_vec_a: assert property (
        ##1 flags.spindle_below_min_speed == $past(below_cmp))
        else $error("below-min flags off");

    per_tool_set_a: assert property (
        life_mode == NSF_LIFE_PER_TOOL && tool.count_reached
        |=> flags.tool_group_expired)
        else $error("tool over life not flagged");

    lathe_set_a: assert property (
        life_mode == NSF_LIFE_LATHE && tool.tool_function_strobe
            && tool.group_all_expired
        |=> flags.tool_group_expired)
        else $error("expired group selection not flagged");

    lathe_clear_a: assert property (
        life_mode == NSF_LIFE_LATHE && tool.usage_cleared
            && !tool.last_tool && !tool.tool_function_strobe
        |=> !flags.tool_group_expired)
        else $error("usage clear left expired flag");

    mc_error_set_a: assert property (
        life_mode == NSF_LIFE_MC && !tool.spindle_tool_change
            && tool.last_tool && tool.tool_error
        |=> flags.tool_group_expired)
        else $error("tool error on last tool not flagged");

    mc_mount_clear_a: assert property (
        mc_mount_live_s ##1 mc_idle_s |=> !flags.tool_group_expired)
        else $error("live mount left expired flag");

    mc_disable_a: assert property (
        life_mode == NSF_LIFE_MC && !life_en
            && !tool.spindle_tool_change && !tool.last_tool
            && !(st_reg.mount_pend && st_reg.mount_expired)
        |=> !flags.tool_group_expired)
        else $error("disabled life management kept flag");

endmodule : nsf_status_flags

// ==== verification/nsf_ladder_model.sv ====
`timescale 1ns/1ns
module nsf_ladder_model
    import nsf_pkg::*;
#(
    parameter int SCAN = 4
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       lock_want,
    input  wire nsf_flags_s flags,
    output logic            position_display_freeze_request,
    output nsf_flags_s      scanned
);
    int unsigned phase = 0;

    // Quiet outputs before the first scan
    initial begin
        position_display_freeze_request = 1'b0;
        scanned = '0;
    end

    // Ladder outputs move just after an edge; flags are read once a scan,
    // so a flag moving inside a scan is only seen on the next scan
    always @(posedge clk) begin
        position_display_freeze_request <= reset_n & lock_want;
        phase <= (!reset_n || phase == SCAN - 1) ? 0 : phase + 1;
        if (phase == 0) begin
            scanned <= flags;
        end
    end
endmodule : nsf_ladder_model

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb;
    import nsf_pkg::*;
    localparam int SCAN = 4;
    logic                   clk          = 1'b0;
    logic                   reset_n      = 1'b0;
    logic [7:0]             reg_addr     = 8'h00;
    logic [31:0]            reg_wdata    = 32'h0000_0000;
    logic                   reg_wr       = 1'b0;
    logic                   reg_rd       = 1'b0;
    logic [31:0]            reg_rdata;
    logic [NSF_ASYNC_W-1:0] async_pins   = 4'h9;
    logic                   lock_want    = 1'b0;
    logic                   freeze_req;
    nsf_motion_s            motion       = '0;
    nsf_tool_s              tool         = '0;
    logic [1:0][15:0]       fb           = {16'h0064, 16'h0064};
    logic [1:0][15:0]       smax         = {16'h00C8, 16'h00C8};
    logic [1:0][15:0]       smin         = {16'h0032, 16'h0032};
    nsf_flags_s             flags;
    nsf_flags_s             scanned;
    nsf_flags_s             ef           = '0;
    logic                   permit;
    logic [31:0]            q;
    int                     fail_count   = 0;
    int                     total_checks = 0;
    // Speed table: below, above, feedback 1, feedback 0
    logic [35:0] speed_tab [5] = '{36'h0_0064_00C8, 36'h1_0064_00C9,
        36'h4_0032_0031, 36'h9_0031_00C9, 36'h0_0064_0064};
    // Tool life table: ctrl, tool events, extra wait, expected flag
    logic [27:0] lf [19] = '{28'h041_0001, 28'h040_0400, 28'h0C1_0000,
        28'h0C1_8001, 28'h0C0_1000, 28'h0C0_C001, 28'h0C0_0400,
        28'h0C0_2801, 28'h0C0_1801, 28'h0C0_1000, 28'h140_0A00,
        28'h140_0031, 28'h140_0400, 28'h140_8101, 28'h140_0230,
        28'h140_8330, 28'h141_8001, 28'h100_0000, 28'h1C1_8000};

    // Free-running 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end

    nsf_status_flags i_nsf_status_flags (
        .clk                             (clk),
        .reset_n                         (reset_n),
        .reg_addr                        (reg_addr),
        .reg_wdata                       (reg_wdata),
        .reg_wr                          (reg_wr),
        .reg_rd                          (reg_rd),
        .reg_rdata                       (reg_rdata),
        .async_pins                      (async_pins),
        .position_display_freeze_request (freeze_req),
        .motion                          (motion),
        .tool                            (tool),
        .spindle_speed_fb                (fb),
        .spindle_max_speed               (smax),
        .spindle_min_speed               (smin),
        .flags                           (flags),
        .auto_start_permit               (permit)
    );

    nsf_ladder_model #(.SCAN(SCAN)) i_nsf_ladder_model (
        .clk                             (clk),
        .reset_n                         (reset_n),
        .lock_want                       (lock_want),
        .flags                           (flags),
        .position_display_freeze_request (freeze_req),
        .scanned                         (scanned)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Settle on the falling edge so registered flags have landed
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : look

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        q = reg_rdata;
    endtask : rd

    task automatic pm(input nsf_motion_s m);
        @(posedge clk);
        motion <= m;
        @(posedge clk);
        motion <= '0;
        look(0);
    endtask : pm

    // Level qualifiers ride along with the pulses, then drop together
    task automatic pt(input nsf_tool_s t, input int n);
        @(posedge clk);
        tool <= t;
        @(posedge clk);
        tool <= '0;
        look(n);
    endtask : pt

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Main sequence: power-on with strap and weak cell, then each flag
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        look(6);
        ef.inch_unit_flag = 1'b1;
        ef.backup_cell_low_alarm = 1'b1;
        chk(32'(flags), 32'(ef));
        @(posedge clk);
        async_pins <= 4'h1;
        look(5);
        chk(32'(flags), 32'(ef));
        wr(NSF_CMD_OFS, 32'h0000_0001);
        look(1);
        ef.backup_cell_low_alarm = 1'b0;
        chk(32'(flags), 32'(ef));
        @(posedge clk);
        lock_want <= 1'b1;
        look(2);
        ef.position_display_frozen_flag = 1'b1;
        chk(32'(flags), 32'(ef));
        rd(NSF_STATUS_OFS);
        chk(q, 32'(ef));
        @(posedge clk);
        lock_want <= 1'b0;
        look(2);
        ef.position_display_frozen_flag = 1'b0;
        chk(32'(flags), 32'(ef));
        // Feed codes refused until both enables are set
        wr(NSF_CTRL_OFS, 32'h0000_0001);
        pm(nsf_motion_s'(8'hB0));
        chk(32'(flags), 32'(ef));
        wr(NSF_CTRL_OFS, 32'h0000_0003);
        for (int c = 0; c < 8; c++) begin
            pm(nsf_motion_s'(8'h80 | 8'(c << 4)));
            ef.single_digit_feed_active = (c >= 1 && c <= 5);
            chk(32'(flags), 32'(ef));
            pm(nsf_motion_s'(8'(1 << (c % 4))));
            ef.single_digit_feed_active = 1'b0;
            chk(32'(flags), 32'(ef));
        end
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            fb <= speed_tab[i][31:0];
            look(1);
            {ef.spindle_below_min_speed, ef.spindle_above_max_speed} =
                speed_tab[i][35:32];
            chk(32'(flags), 32'(ef));
        end
        for (int i = 0; i < 19; i++) begin
            wr(NSF_CTRL_OFS, 32'(lf[i][27:20]));
            pt(nsf_tool_s'(lf[i][16:8]), int'(lf[i][7:4]));
            ef.tool_wear_tracking_active = lf[i][22];
            ef.tool_group_expired = lf[i][0];
            chk(32'(flags), 32'(ef));
            chk(32'(permit), 32'h0000_0001);
        end
        // Absolute supply fault first, then the speed detector fault
        @(posedge clk);
        async_pins <= 4'h3;
        look(5);
        ef.abs_alarm = 1'b1;
        chk(32'(flags), 32'(ef));
        chk(32'(permit), 32'h0000_0001);
        @(posedge clk);
        async_pins <= 4'h7;
        look(5);
        ef.speed_alarm = 1'b1;
        chk(32'(flags), 32'(ef));
        chk(32'(permit), 32'h0000_0000);
        @(posedge clk);
        async_pins <= 4'h1;
        wr(NSF_CMD_OFS, 32'h0000_0001);
        look(5);
        chk(32'(flags), 32'(ef));
        rd(8'h0C);
        chk(q, 32'h0000_0000);
        wr(NSF_STATUS_OFS, 32'hFFFF_FFFF);
        rd(NSF_STATUS_OFS);
        chk(q, 32'(ef));
        rd(NSF_CTRL_OFS);
        chk(q, 32'h0000_001C);
        look(SCAN);
        chk(32'(scanned), 32'(ef));
        // Power cycle: supply alarms gone, weak cell found again
        @(posedge clk);
        reset_n <= 1'b0;
        look(2);
        chk(32'(flags), 32'h0000_0000);
        chk(32'(permit), 32'h0000_0001);
        @(posedge clk);
        reset_n <= 1'b1;
        look(6);
        ef = '0;
        ef.backup_cell_low_alarm = 1'b1;
        chk(32'(flags), 32'(ef));
        final_report();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule : tb
